//--- design/aout_map.svh
// Offsets, field positions, bus command codes and timing constants of the analog output register block.
`ifndef AOUT_MAP_SVH
`define AOUT_MAP_SVH

// I/O window decoded relative to the assigned base; 128 bytes wide.
`define AO_WIN_LSB 7
`define AO_OFF_CH_FIRST 8'h00
`define AO_OFF_CH_LAST 8'h0e
`define AO_OFF_STATUS 8'h00
`define AO_OFF_RSV_FIRST 8'h10
`define AO_OFF_RSV_LAST 8'h3e
`define AO_OFF_DIO 8'h40
`define AO_OFF_RANGE 8'h44

// Field layout.
`define AO_CODE_W 12
`define AO_STATUS_BUSY_BIT 0
`define AO_DIO_OUT_LSB 0
`define AO_DIO_IN_LSB 4
`define AO_RANGE_W 2

// Bus command codes for I/O cycles, active-low byte enables.
`define AO_CMD_IO_READ 4'h2
`define AO_CMD_IO_WRITE 4'h3

// Serial transfer timing.
`define AO_CLK_NS 10
`define AO_XFER_NS 16000
`define AO_XFER_BITS 16
`define AO_XFER_CYC ((`AO_XFER_NS + `AO_CLK_NS - 1) / `AO_CLK_NS)
`define AO_BIT_CYC (`AO_XFER_CYC / `AO_XFER_BITS)
`define AO_BIT_HALF (`AO_BIT_CYC / 2)

`endif

//--- design/aout_pkg.sv
// Types shared by the analog output register block and its serial converter link.
package aout_pkg;

    // Bus target sequencing, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_CLAIM = 4'b0010,
        ST_XFER  = 4'b0100,
        ST_TURN  = 4'b1000
    } bus_state_e;

    // Current range modes; code 2 has no meaning.
    typedef enum logic [1:0] {
        RANGE_0_20MA = 2'h0,
        RANGE_5_25MA = 2'h1,
        RANGE_BAD    = 2'h2,
        RANGE_4_20MA = 2'h3
    } range_e;

    // Complete state of the register block.
    typedef struct packed {
        bus_state_e st;
        logic is_write;
        logic done;
        logic [7:0] off;
        logic [31:0] ad_out;
        logic ad_oe;
        logic [3:0] cbe_q;
        logic par;
        logic par_oe;
        logic [3:0] iso_out;
        range_e range;
        logic pend;
        logic [2:0] pend_ch;
        logic [11:0] pend_code;
        logic start;
        logic [2:0] go_ch;
        logic [11:0] go_code;
        logic [3:0] in_s1;
        logic [3:0] in_s2;
        logic [3:0] in_s3;
        logic [3:0] in_stable;
    } regs_s;

    // Complete state of the serial converter link.
    typedef struct packed {
        logic active;
        logic [6:0] ph;
        logic [3:0] bits;
        logic [15:0] shreg;
        logic [2:0] ch;
        logic sclk;
        logic sdata;
        logic [7:0] load;
    } ser_s;

endpackage

//--- design/dac_link_if.sv
// Carrier between the register block and the serial converter link.
`timescale 1ns/1ps
`default_nettype none
interface dac_link_if;
    logic start;        // One-cycle request to send a code.
    logic [2:0] ch;     // Target converter channel.
    logic [11:0] code;  // Straight binary code.
    logic busy;         // High while a code is being shifted.

    modport ctrl(output start, output ch, output code, input busy);
    modport ser(input start, input ch, input code, output busy);
endinterface
`default_nettype wire

//--- design/dac_serializer.sv
// Serial shifter that sends one twelve-bit code to a converter per request.
`timescale 1ns/1ps
`default_nettype none
`include "aout_map.svh"
module dac_serializer (
    input wire logic i_clk,
    input wire logic i_rstn,
    dac_link_if.ser link,
    output logic o_sclk,
    output logic o_sdata,
    output logic [7:0] o_load
);
    localparam aout_pkg::ser_s RESET_STATE = '0;

    aout_pkg::ser_s r_reg;   // Registered state.
    aout_pkg::ser_s r_next;  // Next state.

    // The frame is sixteen bit times, four zero pad bits then the code, msb first.
    always_comb begin
        r_next = r_reg;
        r_next.load = 8'h00;
        if (!r_reg.active) begin
            // A request is taken only when idle; the block above never sends one while busy.
            if (link.start) begin
                r_next.active = 1'b1;
                r_next.ph = 7'h00;
                r_next.bits = 4'h0;
                r_next.shreg = {4'h0, link.code};
                r_next.ch = link.ch;
                r_next.sdata = 1'b0;
            end
        end else begin
            r_next.ph = r_reg.ph + 7'h01;
            if (r_reg.ph == 7'(`AO_BIT_HALF - 1)) begin
                // Converter samples on the rising edge, mid bit.
                r_next.sclk = 1'b1;
            end
            if (r_reg.ph == 7'(`AO_BIT_CYC - 1)) begin
                r_next.ph = 7'h00;
                r_next.sclk = 1'b0;
                r_next.shreg = {r_reg.shreg[14:0], 1'b0};
                r_next.sdata = r_reg.shreg[14];
                r_next.bits = r_reg.bits + 4'h1;
                if (r_reg.bits == 4'(`AO_XFER_BITS - 1)) begin
                    // Whole transfer time elapsed: latch the code into the target.
                    r_next.active = 1'b0;
                    r_next.load[r_reg.ch] = 1'b1;
                end
            end
        end
    end

    // Single register stage; reset drops any partial frame.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            r_reg <= RESET_STATE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.busy = r_reg.active;
    assign o_sclk = r_reg.sclk;
    assign o_sdata = r_reg.sdata;
    assign o_load = r_reg.load;
endmodule
`default_nettype wire

//--- design/analog_output_io_registers.sv
// I/O register block of an eight-channel analog output board on a 32-bit bus.
// Summary of operation
// - Bus target decoding I/O from assigned base.
// - Registers sixteen bits, sixteen-bit I/O cycles.
// - Offsets 00h-0Eh load channels 3..0, 7..4.
// - Write-only twelve-bit codes, upper nibble unused.
// - Codes are unsigned straight binary, full span.
// - Offsets 10h to 3Eh are reserved.
// - Write 40h drives four isolated outputs.
// - Read 40h returns inputs and output readback.
// - Read 00h returns busy flag on bit 0.
// - Each channel write shifts sixteen microseconds.
// - One current range mode for all channels.
`timescale 1ns/1ps
`default_nettype none
`include "aout_map.svh"
module analog_output_io_registers (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic [31:0] I_IO_BASE,
    input wire logic [31:0] I_AD,
    input wire logic [3:0] I_CBE_N,
    input wire logic I_FRAME_N,
    input wire logic I_IRDY_N,
    output logic [31:0] O_AD,
    output logic O_AD_OE,
    output logic O_PAR,
    output logic O_PAR_OE,
    output logic O_DEVSEL_N,
    output logic O_TRDY_N,
    output logic O_STOP_N,
    output logic O_CTL_OE,
    input wire logic [3:0] I_ISO_IN,
    output logic [3:0] O_ISO_OUT,
    output logic [1:0] O_RANGE_MODE,
    output logic O_DAC_SCLK,
    output logic O_DAC_SDATA,
    output logic [7:0] O_DAC_LOAD
);
    localparam aout_pkg::regs_s RESET_STATE = '{st: aout_pkg::ST_IDLE, range: aout_pkg::RANGE_0_20MA, default: '0};

    aout_pkg::regs_s r_reg;   // Registered state of the block.
    aout_pkg::regs_s r_next;  // Next value of the state.
    logic ser_busy;            // Converter link is shifting.
    logic flag_busy;           // Busy as seen by software.
    logic [15:0] rd_word;      // Read data of the latched offset.
    logic [15:0] wr_word;      // Write data taken from the addressed lane.
    logic [1:0] wr_be_n;       // Byte enables of the addressed lane.

    dac_link_if link();

    // Maps a channel register index to its converter: indices 0..3 are channels 3..0 and 4..7 are 7..4.
    function automatic logic [2:0] chan_of(input logic [2:0] idx);
        chan_of = {idx[2], ~idx[1:0]};
    endfunction

    // True for the eight channel register offsets.
    function automatic logic is_chan(input logic [7:0] off);
        is_chan = (off >= `AO_OFF_CH_FIRST) && (off <= `AO_OFF_CH_LAST);
    endfunction

    // Busy covers a held code, the request cycle and the shift itself, so polling never sees a gap.
    assign flag_busy = ser_busy | r_reg.pend | r_reg.start;

    // Read multiplexer; every offset without a read function returns zero.
    always_comb begin
        rd_word = 16'h0000;
        if (r_reg.off == `AO_OFF_STATUS) begin
            rd_word[`AO_STATUS_BUSY_BIT] = flag_busy;
        end else if (r_reg.off == `AO_OFF_DIO) begin
            rd_word[`AO_DIO_IN_LSB +: 4] = r_reg.in_stable;
            rd_word[`AO_DIO_OUT_LSB +: 4] = r_reg.iso_out;
        end else if (r_reg.off == `AO_OFF_RANGE) begin
            rd_word[`AO_RANGE_W - 1:0] = r_reg.range;
        end
    end

    // Sixteen-bit registers sit in the lane chosen by byte address bit 1.
    always_comb begin
        if (r_reg.off[1]) begin
            wr_word = I_AD[31:16];
            wr_be_n = I_CBE_N[3:2];
        end else begin
            wr_word = I_AD[15:0];
            wr_be_n = I_CBE_N[1:0];
        end
    end

    // Next-state logic: bus target sequence, register writes, converter hand-off and input filter.
    always_comb begin
        r_next = r_reg;
        r_next.start = 1'b0;
        r_next.cbe_q = I_CBE_N;
        // Parity follows the driven data one cycle later and covers AD and C/BE of the same cycle.
        r_next.par = ^{r_reg.ad_out, I_CBE_N};
        r_next.par_oe = r_reg.ad_oe;

        // Isolated inputs come from off-board: three stages, a change counts once stages two and three agree.
        r_next.in_s1 = I_ISO_IN;
        r_next.in_s2 = r_reg.in_s1;
        r_next.in_s3 = r_reg.in_s2;
        for (int b = 0; b < 4; b++) begin
            if (r_reg.in_s2[b] == r_reg.in_s3[b]) begin
                r_next.in_stable[b] = r_reg.in_s3[b];
            end
        end

        // A held code is issued as soon as the link is free; the latest write wins.
        if (r_reg.pend && !ser_busy && !r_reg.start) begin
            r_next.start = 1'b1;
            r_next.go_ch = r_reg.pend_ch;
            r_next.go_code = r_reg.pend_code;
            r_next.pend = 1'b0;
        end

        case (r_reg.st)
            aout_pkg::ST_IDLE: begin
                r_next.done = 1'b0;
                // Address phase: I/O command whose address falls inside our window.
                if (!I_FRAME_N && (I_AD[31:`AO_WIN_LSB] == I_IO_BASE[31:`AO_WIN_LSB]) &&
                    ((I_CBE_N == `AO_CMD_IO_READ) || (I_CBE_N == `AO_CMD_IO_WRITE))) begin
                    r_next.st = aout_pkg::ST_CLAIM;
                    r_next.is_write = (I_CBE_N == `AO_CMD_IO_WRITE);
                    r_next.off = {1'b0, I_AD[`AO_WIN_LSB - 1:1], 1'b0};
                end
            end
            aout_pkg::ST_CLAIM: begin
                // Turnaround cycle; read data is put on the bus for the data phase.
                r_next.st = aout_pkg::ST_XFER;
                if (!r_reg.is_write) begin
                    r_next.ad_out = {rd_word, rd_word};
                    r_next.ad_oe = 1'b1;
                end
            end
            aout_pkg::ST_XFER: begin
                if (!I_IRDY_N && !r_reg.done) begin
                    r_next.done = 1'b1;
                    r_next.ad_oe = 1'b0;
                    if (r_reg.is_write) begin
                        if (is_chan(r_reg.off)) begin
                            // Code bits 11:0 are kept; bits 15:12 are dropped.
                            r_next.pend = 1'b1;
                            r_next.pend_ch = chan_of(r_reg.off[3:1]);
                            r_next.pend_code = wr_word[`AO_CODE_W - 1:0];
                        end else if ((r_reg.off == `AO_OFF_DIO) && !wr_be_n[0]) begin
                            r_next.iso_out = wr_word[`AO_DIO_OUT_LSB +: 4];
                        end else if ((r_reg.off == `AO_OFF_RANGE) && !wr_be_n[0]) begin
                            // The undefined code is refused so the outputs never enter it.
                            if (wr_word[`AO_RANGE_W - 1:0] != aout_pkg::RANGE_BAD) begin
                                r_next.range = aout_pkg::range_e'(wr_word[`AO_RANGE_W - 1:0]);
                            end
                        end
                        // Reserved and other offsets take no action.
                    end
                end
                // Leave once the one data phase is done and the master has dropped FRAME.
                if ((r_reg.done || !I_IRDY_N) && I_FRAME_N) begin
                    r_next.st = aout_pkg::ST_TURN;
                end
            end
            aout_pkg::ST_TURN: begin
                // Control lines are driven high for one cycle before release.
                r_next.st = aout_pkg::ST_IDLE;
            end
            default: begin
                r_next.st = aout_pkg::ST_IDLE;
            end
        endcase
    end

    // Single register stage; synchronous reset clears outputs, held code and busy.
    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            r_reg <= RESET_STATE;
        end else begin
            r_reg <= r_next;
        end
    end

    // Converter hand-off over the link carrier.
    assign link.start = r_reg.start;
    assign link.ch = r_reg.go_ch;
    assign link.code = r_reg.go_code;
    assign ser_busy = link.busy;

    dac_serializer u_ser (
        .i_clk(I_CLK),
        .i_rstn(I_RSTN),
        .link(link),
        .o_sclk(O_DAC_SCLK),
        .o_sdata(O_DAC_SDATA),
        .o_load(O_DAC_LOAD)
    );

    // Handshake lines; the burst stop keeps each transaction to one data phase.
    assign O_DEVSEL_N = !((r_reg.st == aout_pkg::ST_CLAIM) || (r_reg.st == aout_pkg::ST_XFER));
    assign O_TRDY_N = !((r_reg.st == aout_pkg::ST_XFER) && !r_reg.done);
    assign O_STOP_N = !((r_reg.st == aout_pkg::ST_XFER) && !I_FRAME_N);
    assign O_CTL_OE = (r_reg.st != aout_pkg::ST_IDLE);
    assign O_AD = r_reg.ad_out;
    assign O_AD_OE = r_reg.ad_oe;
    assign O_PAR = r_reg.par;
    assign O_PAR_OE = r_reg.par_oe;
    assign O_ISO_OUT = r_reg.iso_out;
    assign O_RANGE_MODE = r_reg.range;
endmodule
`default_nettype wire

//--- testbench/aout_chk.sv
// Assertions on the bus target and converter link of the analog output register block.
`timescale 1ns/1ps
`default_nettype none
module aout_chk (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic [31:0] I_IO_BASE,
    input wire logic [31:0] I_AD,
    input wire logic [3:0] I_CBE_N,
    input wire logic I_FRAME_N,
    input wire logic I_IRDY_N,
    input wire logic O_AD_OE,
    input wire logic O_DEVSEL_N,
    input wire logic O_TRDY_N,
    input wire logic O_CTL_OE,
    input wire logic [3:0] O_ISO_OUT,
    input wire logic [1:0] O_RANGE_MODE,
    input wire logic O_DAC_SCLK,
    input wire logic [7:0] O_DAC_LOAD,
    input wire logic [31:0] O_AD,
    input wire logic O_PAR,
    input wire logic O_PAR_OE,
    input wire logic O_STOP_N
);
    // A data phase completes when target and master are both ready.
    logic done;
    // An I/O address phase seen while the target is idle.
    logic io_cmd;
    assign done = !O_TRDY_N && !I_IRDY_N;
    assign io_cmd = !I_FRAME_N && I_CBE_N[3:1] == 3'h1 && !O_CTL_OE;
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RSTN);
    AST_CLAIM: assert property (io_cmd && I_AD[31:7] == I_IO_BASE[31:7] |=> !O_DEVSEL_N && O_CTL_OE)
        else $error("cycle in window not claimed");
    AST_FOREIGN: assert property (io_cmd && I_AD[31:7] != I_IO_BASE[31:7] |=> O_DEVSEL_N && !O_CTL_OE)
        else $error("foreign cycle claimed");
    AST_READY: assert property ($fell(O_DEVSEL_N) |=> !O_TRDY_N && !O_DEVSEL_N)
        else $error("ready late after claim");
    AST_WAIT: assert property (!O_TRDY_N && I_IRDY_N |=> !O_TRDY_N)
        else $error("ready dropped early");
    AST_TURN: assert property (done |=> O_TRDY_N && O_DEVSEL_N && O_CTL_OE ##1 !O_CTL_OE)
        else $error("bad turnaround");
    AST_RDATA: assert property ($fell(O_DEVSEL_N) |=> O_AD_OE == ($past(I_CBE_N, 2) == 4'h2))
        else $error("read data drive wrong");
    // The reset term keeps the clearing by reset out of these two.
    AST_DOUT: assert property ($changed(O_ISO_OUT) && $past(I_RSTN) |-> $past(done))
        else $error("outputs moved without write");
    AST_RANGE: assert property ($changed(O_RANGE_MODE) && $past(I_RSTN) |-> $past(done) && O_RANGE_MODE != 2'h2)
        else $error("range changed wrongly");
    AST_LOAD: assert property (|O_DAC_LOAD |-> $onehot(O_DAC_LOAD) ##1 O_DAC_LOAD == 8'h00)
        else $error("load pulse malformed");
    AST_SCLK: assert property ($rose(O_DAC_SCLK) |-> ##49 O_DAC_SCLK ##1 !O_DAC_SCLK)
        else $error("serial clock high time wrong");
    // Parity covers the driven data and the command lines of the cycle before.
    AST_PAR: assert property (O_PAR_OE |-> O_PAR == ^{$past(O_AD), $past(I_CBE_N)})
        else $error("parity wrong");
    // A master that keeps FRAME low is stopped so that only one data phase is taken.
    AST_STOP: assert property (!O_TRDY_N && !I_FRAME_N |-> !O_STOP_N)
        else $error("burst not stopped");
endmodule
`default_nettype wire

//--- testbench/pci_io_master.sv
// Bus master model issuing single sixteen-bit I/O cycles.
`timescale 1ns/1ps
`default_nettype none
module pci_io_master (
    input wire logic i_clk,
    input wire logic i_trdy_n,
    input wire logic [31:0] i_ad,
    output logic [31:0] o_ad,
    output logic [3:0] o_cbe_n,
    output logic o_frame_n,
    output logic o_irdy_n
);
    // Cycles the master stays unready in the data phase.
    int lag = 0;
    initial begin
        o_ad = 32'h0;
        o_cbe_n = 4'hf;
        o_frame_n = 1'b1;
        o_irdy_n = 1'b1;
    end
    // One transfer; ok stays low if no target is ready within eight cycles.
    task automatic io(input logic wr, input logic [31:0] adr, input logic [15:0] wd,
                      output logic [15:0] rd, output logic ok);
        ok = 1'b0;
        rd = 16'h0;
        @(posedge i_clk);
        o_frame_n <= 1'b0;
        o_ad <= adr;
        o_cbe_n <= {3'h1, wr};
        @(posedge i_clk);
        o_ad <= wr ? {wd, wd} : ~adr;
        o_cbe_n <= adr[1] ? 4'h3 : 4'hc;
        repeat (lag) @(posedge i_clk);
        o_frame_n <= 1'b1;
        o_irdy_n <= 1'b0;
        // Ready and read data are taken at the rising edge that completes the data phase.
        for (int n = 0; n < 8 && !ok; n++) begin
            @(posedge i_clk);
            ok = !i_trdy_n;
            rd = adr[1] ? i_ad[31:16] : i_ad[15:0];
        end
        // Release at the completing edge, leaving a changed pattern.
        o_irdy_n <= 1'b1;
        o_ad <= ~o_ad;
        o_cbe_n <= 4'hf;
        // One more edge so that the effect of a write has settled when the caller looks.
        @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the analog output register block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    // Assigned base; the low seven bits are inside the window.
    localparam logic [31:0] BASE = 32'h0000_e000;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] iso_in = 4'h0;
    logic [31:0] ad_m, ad_d;
    logic [3:0] cbe_n, iso_out;
    logic frame_n, irdy_n, trdy_n, sclk, sdata;
    logic [1:0] rmode;
    logic [7:0] load;
    // Converter side: shifted word, bit count, last strobe.
    logic sclk_q = 1'b0;
    logic [15:0] sh = 16'h0;
    logic [15:0] cap = 16'h0;
    logic [7:0] last_load = 8'h0;
    int nbits = 0;
    int cap_bits = 0;
    int nload = 0;
    int cyc = 0;
    int fail_count = 0;
    int check_count = 0;
    logic [11:0] codes [8] = '{12'h000, 12'hfff, 12'h800, 12'h5a3, 12'h001, 12'hffe, 12'h7ff, 12'h3c4};
    logic [7:0] rsv [4] = '{8'h02, 8'h0e, 8'h10, 8'h3e};
    logic [1:0] mode [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
    logic [1:0] mexp [4] = '{2'h3, 2'h1, 2'h1, 2'h0};

    always #5 clk = ~clk;

    analog_output_io_registers dut_u (.I_CLK(clk), .I_RSTN(rstn), .I_IO_BASE(BASE), .I_AD(ad_m),
        .I_CBE_N(cbe_n), .I_FRAME_N(frame_n), .I_IRDY_N(irdy_n), .O_AD(ad_d), .O_AD_OE(), .O_PAR(),
        .O_PAR_OE(), .O_DEVSEL_N(), .O_TRDY_N(trdy_n), .O_STOP_N(), .O_CTL_OE(), .I_ISO_IN(iso_in),
        .O_ISO_OUT(iso_out), .O_RANGE_MODE(rmode), .O_DAC_SCLK(sclk), .O_DAC_SDATA(sdata), .O_DAC_LOAD(load));

    pci_io_master m_u (.i_clk(clk), .i_trdy_n(trdy_n), .i_ad(ad_d), .o_ad(ad_m), .o_cbe_n(cbe_n),
        .o_frame_n(frame_n), .o_irdy_n(irdy_n));

    // Shift data in on each rising serial clock; keep the word at each strobe.
    always @(posedge clk) begin
        sclk_q <= sclk;
        cyc <= cyc + 1;
        if (!rstn) begin
            nbits <= 0;
        end else if (sclk && !sclk_q) begin
            sh <= {sh[14:0], sdata};
            nbits <= nbits + 1;
        end
        if (|load) begin
            cap <= sh;
            cap_bits <= nbits;
            last_load <= load;
            nload <= nload + 1;
            nbits <= 0;
        end
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] off, input logic [15:0] d);
        logic [15:0] rd;
        logic ok;
        m_u.io(1'b1, BASE | off, d, rd, ok);
        chk("write claim", 16'h1, {15'h0, ok});
    endtask

    task automatic rdc(input string name, input logic [7:0] off, input logic [15:0] exp, input logic [15:0] msk);
        logic [15:0] rd;
        logic ok;
        m_u.io(1'b0, BASE | off, 16'h0, rd, ok);
        chk(name, exp, ok ? rd & msk : 16'hxxxx);
    endtask

    // Poll busy as the host must, bounded.
    task automatic wait_idle();
        logic [15:0] rd;
        logic ok;
        int n;
        n = 0;
        do begin
            m_u.io(1'b0, BASE, 16'h0, rd, ok);
            n++;
        end while ((ok !== 1'b1 || rd[0] !== 1'b0) && n < 1000);
        if (n == 1000) begin
            fail_count++;
            print_verdict();
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        int t0;
        int n0;
        logic [15:0] rd;
        logic ok;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        iso_in <= 4'h9;
        rdc("status", 8'h00, 16'h0, 16'h1);
        m_u.lag = 3;
        rdc("port", 8'h40, 16'h90, 16'hff);
        m_u.lag = 0;
        wr(8'h40, 16'h00a6);
        rdc("port", 8'h40, 16'h96, 16'hff);
        chk("pins", 16'h6, {12'h0, iso_out});
        $display("test port done");
        for (int i = 0; i < 4; i++) begin
            rdc("unmapped", rsv[i], 16'h0, 16'hffff);
            wr(8'h44, {14'h0, mode[i]});
            chk("range", {14'h0, mexp[i]}, {14'h0, rmode});
        end
        wr(8'h20, 16'hffff);
        rdc("port", 8'h40, 16'h96, 16'hff);
        chk("range", 16'h0, {14'h0, rmode});
        $display("test map done");
        for (int i = 0; i < 8; i++) begin
            wr(8'(2 * i), {4'hf, codes[i]});
            t0 = cyc;
            rdc("busy", 8'h00, 16'h1, 16'h1);
            wait_idle();
            chk("span", 16'h1, {15'h0, cyc - t0 >= 1600 && cyc - t0 <= 1620});
            chk("strobe", {8'h0, 8'h1 << (i < 4 ? 3 - i : 11 - i)}, {8'h0, last_load});
            chk("word", {4'h0, codes[i]}, cap);
            chk("bits", 16'd16, 16'(cap_bits));
        end
        $display("test channels done");
        n0 = nload;
        wr(8'h00, 16'h0123);
        wr(8'h02, 16'h0456);
        wait_idle();
        chk("held", 16'h2, 16'(nload - n0));
        chk("word", 16'h0456, cap);
        wr(8'h44, 16'h0003);
        wr(8'h06, 16'h0abc);
        repeat (300) @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        n0 = nload;
        rdc("status", 8'h00, 16'h0, 16'h1);
        rdc("port", 8'h40, 16'h90, 16'hff);
        repeat (1700) @(posedge clk);
        chk("late strobe", 16'h0, 16'(nload - n0));
        chk("range", 16'h0, {14'h0, rmode});
        m_u.io(1'b1, BASE + 32'hc0, 16'h000f, rd, ok);
        chk("foreign", 16'h0, {15'h0, ok});
        chk("pins", 16'h0, {12'h0, iso_out});
        $display("test reset done");
        print_verdict();
    end
endmodule

bind analog_output_io_registers aout_chk chk_u (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_IO_BASE(I_IO_BASE),
    .I_AD(I_AD), .I_CBE_N(I_CBE_N), .I_FRAME_N(I_FRAME_N), .I_IRDY_N(I_IRDY_N), .O_AD_OE(O_AD_OE),
    .O_DEVSEL_N(O_DEVSEL_N), .O_TRDY_N(O_TRDY_N), .O_CTL_OE(O_CTL_OE), .O_ISO_OUT(O_ISO_OUT),
    .O_AD(O_AD), .O_PAR(O_PAR), .O_PAR_OE(O_PAR_OE), .O_STOP_N(O_STOP_N),
    .O_RANGE_MODE(O_RANGE_MODE), .O_DAC_SCLK(O_DAC_SCLK), .O_DAC_LOAD(O_DAC_LOAD));
`default_nettype wire
